// File: verilog/msi_pkg.sv
package msi_pkg;

  // ----------------------------------------
  // clock and timebase
  // ----------------------------------------
  localparam int CLK_HZ           = 40_000_000;
  localparam int BLINK_PERIOD_MS  = 1000;
  localparam int BLINK_PERIOD_CYC = CLK_HZ / 1000 * BLINK_PERIOD_MS;
  localparam int ACT_FLASH_MS     = 50;
  localparam int ACT_FLASH_CYC    = CLK_HZ / 1000 * ACT_FLASH_MS;

  // ----------------------------------------
  // frame buffers
  // ----------------------------------------
  localparam int FRAME_W            = 32;
  localparam int FIFO_DEPTH_COMPACT = 256;
  localparam int FIFO_DEPTH_FULL    = 1000;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam int         ADDR_W       = 8;
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_CFG_CAN  = 8'h08;
  localparam logic [7:0] REG_CFG_FILT = 8'h0c;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_CLR  = 8'h14;
  localparam logic [7:0] REG_IRQ_EN   = 8'h18;
  localparam logic [7:0] REG_ERR      = 8'h1c;
  localparam logic [7:0] REG_CFG_UART = 8'h20;

  localparam int CTRL_CFG_DONE = 0;

  localparam int ST_CFG_MODE = 0;
  localparam int ST_TX_EMPTY = 1;
  localparam int ST_RX_EMPTY = 2;
  localparam int ST_RUN_IND  = 3;
  localparam int ST_FLT_IND  = 4;

  // error vector layout
  localparam int ERR_TX_OVF  = 0;
  localparam int ERR_RX_OVF  = 1;
  localparam int ERR_BUS_OFF = 2;
  localparam int ERR_PASSIVE = 3;
  localparam int ERR_OTHER   = 4;
  localparam int ERR_W       = 5;

  // interrupt event layout
  localparam int EV_TX_OVF   = 0;
  localparam int EV_RX_OVF   = 1;
  localparam int EV_BUS_OFF  = 2;
  localparam int EV_CAN_SENT = 3;
  localparam int EV_NVM_DONE = 4;
  localparam int EV_W        = 5;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [31:0]      CFG_RST    = 32'h0000_0000;
  localparam logic [EV_W-1:0]  IRQ_EN_RST = 5'h00;

  typedef enum logic [1:0]
  {
    MODE_BOOT   = 2'b00,
    MODE_CONFIG = 2'b01,
    MODE_OPER   = 2'b10
  } msi_mode_t;

endpackage

// File: verilog/msi_fifo_if.sv
`timescale 1ns/10ps
interface msi_fifo_if;
  import msi_pkg::*;

  logic               wrValid;
  logic [FRAME_W-1:0] wrData;
  logic               full;
  logic               empty;
  logic               rdValid;
  logic               rdReady;
  logic [FRAME_W-1:0] rdData;

  modport store (input wrValid, wrData, rdReady, output full, empty, rdValid, rdData);
  modport user  (output wrValid, wrData, rdReady, input full, empty, rdValid, rdData);
endinterface

// File: verilog/msi_frame_fifo.sv
`timescale 1ns/10ps
module msi_frame_fifo
  import msi_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH_FULL
)
(
  input wire logic   clk,
  input wire logic   reset_n,
  msi_fifo_if.store  fifo
);

  localparam int               PTR_W    = $clog2(DEPTH);
  localparam int               CNT_W    = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  logic [FRAME_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0]   wrPtr;
  logic [PTR_W-1:0]   rdPtr;
  logic [CNT_W-1:0]   count;
  logic [PTR_W-1:0]   next_wrPtr;
  logic [PTR_W-1:0]   next_rdPtr;
  logic [CNT_W-1:0]   next_count;
  logic               doWr;
  logic               doRd;

  // depth is not a power of two in the full variant, so wrap explicitly
  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    return (p == PTR_LAST) ? '0 : p + 1'b1;
  endfunction

  assign fifo.full    = (count == CNT_FULL);
  assign fifo.empty   = (count == '0);
  assign fifo.rdValid = ~fifo.empty;
  assign fifo.rdData  = mem[rdPtr];
  assign doWr         = fifo.wrValid & ~fifo.full;
  assign doRd         = fifo.rdValid & fifo.rdReady;

  always_comb
  begin
    next_wrPtr = doWr ? bump(wrPtr) : wrPtr;
    next_rdPtr = doRd ? bump(rdPtr) : rdPtr;
    next_count = count;
    if (doWr && !doRd)
    begin
      next_count = count + 1'b1;
    end
    else if (doRd && !doWr)
    begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  // storage carries no reset, only the pointers matter
  always_ff @(posedge clk)
  begin
    if (doWr)
    begin
      mem[wrPtr] <= fifo.wrData;
    end
  end

endmodule

// File: verilog/msi_mode_status.sv
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module msi_mode_status
  import msi_pkg::*;
#(
  parameter bit COMPACT   = 1'b0,
  parameter int BLINK_CYC = BLINK_PERIOD_CYC,
  parameter int ACT_CYC   = ACT_FLASH_CYC
)
(
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic [ADDR_W-1:0]  address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [3:0]         byteenable,
  input  wire logic [31:0]        writedata,
  output logic      [31:0]        readdata,
  output logic                    waitrequest,
  output logic                    irq,
  input  wire logic               modeSwitch,
  input  wire logic [31:0]        nvmUartCfg,
  input  wire logic [31:0]        nvmCanCfg,
  input  wire logic [31:0]        nvmFilterCfg,
  output logic                    nvmWrite,
  output logic      [31:0]        activeUartCfg,
  output logic      [31:0]        activeCanCfg,
  output logic      [31:0]        activeFilterCfg,
  input  wire logic               uartRxValid,
  input  wire logic [FRAME_W-1:0] uartRxFrame,
  output logic                    canTxValid,
  output logic      [FRAME_W-1:0] canTxFrame,
  input  wire logic               canTxReady,
  input  wire logic               canRxValid,
  input  wire logic [FRAME_W-1:0] canRxFrame,
  output logic                    uartTxValid,
  output logic      [FRAME_W-1:0] uartTxFrame,
  input  wire logic               uartTxReady,
  input  wire logic               runtimeCanCfgCmd,
  input  wire logic               runtimeFilterCfgCmd,
  input  wire logic [31:0]        runtimeCfgData,
  input  wire logic               statusQueryCmd,
  input  wire logic               errorClearCmd,
  output logic                    errorReportValid,
  output logic      [ERR_W-1:0]   errorReport,
  input  wire logic               canBusOff,
  input  wire logic               canErrorPassive,
  input  wire logic               otherError,
  output logic                    configMode,
  output logic                    runIndicator,
  output logic                    faultIndicator
);

  localparam int          FIFO_DEPTH = COMPACT ? FIFO_DEPTH_COMPACT : FIFO_DEPTH_FULL;
  localparam logic [31:0] BLINK_LAST = 32'(BLINK_CYC - 1);
  localparam logic [31:0] BLINK_HALF = 32'(BLINK_CYC / 2);
  localparam logic [31:0] ACT_LOAD   = 32'(ACT_CYC);

  msi_mode_t        mode;
  msi_mode_t        next_mode;
  logic             ack;
  logic             next_ack;
  logic [31:0]      next_readdata;
  logic [31:0]      next_uartCfg;
  logic [31:0]      next_canCfg;
  logic [31:0]      next_filterCfg;
  logic             next_nvmWrite;
  logic             txOvf;
  logic             rxOvf;
  logic             next_txOvf;
  logic             next_rxOvf;
  logic             busOffSeen;
  logic [EV_W-1:0]  irqStatus;
  logic [EV_W-1:0]  irqEnable;
  logic [EV_W-1:0]  next_irqStatus;
  logic [EV_W-1:0]  next_irqEnable;
  logic [EV_W-1:0]  events;
  logic [ERR_W-1:0] errVec;
  logic             next_reportValid;
  logic [ERR_W-1:0] next_report;
  logic [31:0]      blinkCnt;
  logic [31:0]      actCnt;
  logic [31:0]      next_blinkCnt;
  logic [31:0]      next_actCnt;
  logic             next_runInd;
  logic             next_faultInd;
  logic             opMode;
  logic             busReq;
  logic             wrEn;
  logic             blinkOn;
  logic             txOvfSet;
  logic             rxOvfSet;
  logic             canSent;
  logic             uartSent;
  logic             steadyErr;
  logic             flashErr;

  msi_fifo_if txQ ();
  msi_fifo_if rxQ ();

  function automatic logic [31:0] applyBe(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // frame buffers
  // ----------------------------------------
  msi_frame_fifo #(.DEPTH(FIFO_DEPTH)) txFifo (.clk(clk), .reset_n(reset_n), .fifo(txQ));
  msi_frame_fifo #(.DEPTH(FIFO_DEPTH)) rxFifo (.clk(clk), .reset_n(reset_n), .fifo(rxQ));

  // nothing moves until the mode is known; config mode never converts
  assign opMode         = (mode == MODE_OPER);
  assign configMode     = (mode == MODE_CONFIG);
  assign txQ.wrValid    = opMode & uartRxValid;
  assign txQ.wrData     = uartRxFrame;
  assign txQ.rdReady    = opMode & canTxReady;
  assign canTxValid     = opMode & txQ.rdValid;
  assign canTxFrame     = txQ.rdData;
  assign rxQ.wrValid    = opMode & canRxValid;
  assign rxQ.wrData     = canRxFrame;
  assign rxQ.rdReady    = opMode & uartTxReady;
  assign uartTxValid    = opMode & rxQ.rdValid;
  assign uartTxFrame    = rxQ.rdData;
  assign canSent        = canTxValid & canTxReady;
  assign uartSent       = uartTxValid & uartTxReady;
  // a frame offered while full is dropped, the sticky flag records it
  assign txOvfSet       = txQ.wrValid & txQ.full;
  assign rxOvfSet       = rxQ.wrValid & rxQ.full;

  // ----------------------------------------
  // register bus, one wait state per access
  // ----------------------------------------
  assign busReq      = read | write;
  assign waitrequest = busReq & ~ack;
  assign next_ack    = busReq & ~ack;
  assign wrEn        = write & ack;
  assign irq         = |(irqStatus & irqEnable);

  always_comb
  begin
    next_readdata = readdata;
    if (read && !ack)
    begin
      case (address)
        REG_CTRL:     next_readdata = 32'h0000_0000;
        REG_STATUS:   next_readdata = {27'h0, faultIndicator, runIndicator, rxQ.empty,
                                       txQ.empty, configMode};
        REG_CFG_CAN:  next_readdata = activeCanCfg;
        REG_CFG_FILT: next_readdata = activeFilterCfg;
        REG_CFG_UART: next_readdata = activeUartCfg;
        REG_IRQ_STAT: next_readdata = {27'h0, irqStatus};
        REG_IRQ_EN:   next_readdata = {27'h0, irqEnable};
        REG_ERR:      next_readdata = {27'h0, errVec};
        default:      next_readdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // mode and settings
  // ----------------------------------------
  always_comb
  begin
    next_mode      = mode;
    next_uartCfg   = activeUartCfg;
    next_canCfg    = activeCanCfg;
    next_filterCfg = activeFilterCfg;
    next_nvmWrite  = 1'b0;
    case (mode)
      MODE_BOOT:
      begin
        // switch read once, later moves are ignored until the next reset
        next_mode      = modeSwitch ? MODE_CONFIG : MODE_OPER;
        next_uartCfg   = nvmUartCfg;
        next_canCfg    = nvmCanCfg;
        next_filterCfg = nvmFilterCfg;
      end
      MODE_CONFIG:
      begin
        if (wrEn && address == REG_CFG_UART)
        begin
          next_uartCfg = applyBe(activeUartCfg, writedata, byteenable);
        end
        if (wrEn && address == REG_CFG_CAN)
        begin
          next_canCfg = applyBe(activeCanCfg, writedata, byteenable);
        end
        if (wrEn && address == REG_CFG_FILT)
        begin
          next_filterCfg = applyBe(activeFilterCfg, writedata, byteenable);
        end
        next_nvmWrite = wrEn && address == REG_CTRL && byteenable[0]
                        && writedata[CTRL_CFG_DONE];
      end
      MODE_OPER:
      begin
        if (runtimeCanCfgCmd)
        begin
          next_canCfg = runtimeCfgData;
        end
        if (runtimeFilterCfgCmd)
        begin
          next_filterCfg = runtimeCfgData;
        end
      end
      default:
      begin
        next_mode = MODE_BOOT;
      end
    endcase
  end

  // ----------------------------------------
  // errors, report and interrupts
  // ----------------------------------------
  assign errVec = {otherError, canErrorPassive, canBusOff, rxOvf, txOvf};
  assign events = {next_nvmWrite, canSent, canBusOff & ~busOffSeen, rxOvfSet, txOvfSet};

  always_comb
  begin
    // a new overflow in the clearing cycle survives the clear
    next_txOvf       = txOvfSet | (txOvf & ~errorClearCmd);
    next_rxOvf       = rxOvfSet | (rxOvf & ~errorClearCmd);
    next_reportValid = statusQueryCmd;
    next_report      = statusQueryCmd ? errVec : errorReport;
    next_irqEnable   = (wrEn && address == REG_IRQ_EN) ? writedata[EV_W-1:0] : irqEnable;
    next_irqStatus   = events |
                       (irqStatus & ~((wrEn && address == REG_IRQ_CLR) ?
                                      writedata[EV_W-1:0] : {EV_W{1'b0}}));
  end

  // ----------------------------------------
  // indicators
  // ----------------------------------------
  assign blinkOn   = (blinkCnt < BLINK_HALF);
  // full variant shows every error steady; compact keeps flashing for the rest
  assign steadyErr = COMPACT ? (txOvf | rxOvf | canBusOff | canErrorPassive) : (|errVec);
  assign flashErr  = COMPACT & otherError;

  always_comb
  begin
    next_blinkCnt = (blinkCnt == BLINK_LAST) ? 32'h0000_0000 : blinkCnt + 32'h0000_0001;
    next_actCnt   = (actCnt != 32'h0000_0000) ? actCnt - 32'h0000_0001 : actCnt;
    if (canSent || (COMPACT && uartSent))
    begin
      next_actCnt = ACT_LOAD;
    end
    case (mode)
      MODE_CONFIG: next_runInd = blinkOn;
      // lit while idle, a short dark gap marks each CAN frame sent, and in the compact variant each UART frame too
      MODE_OPER:   next_runInd = (actCnt == 32'h0000_0000);
      default:     next_runInd = 1'b0;
    endcase
    if (steadyErr)
    begin
      next_faultInd = 1'b1;
    end
    else if (flashErr)
    begin
      next_faultInd = blinkOn;
    end
    else
    begin
      next_faultInd = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode             <= MODE_BOOT;
      ack              <= 1'b0;
      readdata         <= 32'h0000_0000;
      activeUartCfg    <= CFG_RST;
      activeCanCfg     <= CFG_RST;
      activeFilterCfg  <= CFG_RST;
      nvmWrite         <= 1'b0;
      txOvf            <= 1'b0;
      rxOvf            <= 1'b0;
      busOffSeen       <= 1'b0;
      irqStatus        <= '0;
      irqEnable        <= IRQ_EN_RST;
      errorReportValid <= 1'b0;
      errorReport      <= '0;
      blinkCnt         <= 32'h0000_0000;
      actCnt           <= 32'h0000_0000;
      runIndicator     <= 1'b0;
      faultIndicator   <= 1'b0;
    end
    else
    begin
      mode             <= next_mode;
      ack              <= next_ack;
      readdata         <= next_readdata;
      activeUartCfg    <= next_uartCfg;
      activeCanCfg     <= next_canCfg;
      activeFilterCfg  <= next_filterCfg;
      nvmWrite         <= next_nvmWrite;
      txOvf            <= next_txOvf;
      rxOvf            <= next_rxOvf;
      busOffSeen       <= canBusOff;
      irqStatus        <= next_irqStatus;
      irqEnable        <= next_irqEnable;
      errorReportValid <= next_reportValid;
      errorReport      <= next_report;
      blinkCnt         <= next_blinkCnt;
      actCnt           <= next_actCnt;
      runIndicator     <= next_runInd;
      faultIndicator   <= next_faultInd;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_MODE_HELD: assert property (@(posedge clk) disable iff (!reset_n)
    (mode != MODE_BOOT) |=> (mode == $past(mode)))
    else $error("mode changed after it was selected");

  AST_MODE_PICK: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && (mode == MODE_BOOT) |=> (configMode == $past(modeSwitch)) && (mode != MODE_BOOT))
    else $error("mode does not follow the switch");

  AST_CFG_BLINK: assert property (@(posedge clk) disable iff (!reset_n)
    configMode && $past(configMode) |-> (runIndicator == ($past(blinkCnt) < BLINK_HALF)))
    else $error("run indicator does not blink in config mode");

  AST_RUN_LIT: assert property (@(posedge clk) disable iff (!reset_n)
    opMode && txQ.empty && actCnt == 32'h0000_0000 |=> runIndicator || !opMode)
    else $error("run indicator dark while idle");

  AST_ACT_FLASH: assert property (@(posedge clk) disable iff (!reset_n)
    canSent |=> ##1 !runIndicator)
    else $error("no flash after a can frame");

  AST_FAULT_DARK: assert property (@(posedge clk) disable iff (!reset_n)
    (errVec == '0) |=> !faultIndicator)
    else $error("fault indicator lit without error");

  AST_FAULT_STEADY: assert property (@(posedge clk) disable iff (!reset_n)
    (txOvf || rxOvf || canBusOff) |=> faultIndicator)
    else $error("fault indicator not lit on error");

  AST_OVF_SET: assert property (@(posedge clk) disable iff (!reset_n)
    txOvfSet |=> txOvf [*2] or (txOvf ##1 $past(errorClearCmd)))
    else $error("overflow not latched");

  AST_CLEAR: assert property (@(posedge clk) disable iff (!reset_n)
    errorClearCmd && !txOvfSet && !rxOvfSet |=> !txOvf && !rxOvf)
    else $error("overflow not cleared");

  AST_QUERY: assert property (@(posedge clk) disable iff (!reset_n)
    statusQueryCmd |=> errorReportValid && (errorReport == $past(errVec)))
    else $error("status report wrong");

  AST_NO_STORE_OP: assert property (@(posedge clk) disable iff (!reset_n)
    opMode && runtimeCanCfgCmd |=> !nvmWrite && (activeCanCfg == $past(runtimeCfgData)))
    else $error("runtime setting not applied or stored");

  AST_STORE: assert property (@(posedge clk) disable iff (!reset_n)
    configMode && wrEn && address == REG_CTRL && byteenable[0] && writedata[CTRL_CFG_DONE]
    |=> nvmWrite ##1 !nvmWrite)
    else $error("store pulse missing");

endmodule

// File: dv/msi_far_side.sv
`timescale 1ns/10ps
module msi_far_side
  import msi_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire logic               stall,
  input  wire logic               canTxValid,
  input  wire logic [FRAME_W-1:0] canTxFrame,
  output logic                    canTxReady,
  input  wire logic               uartTxValid,
  input  wire logic [FRAME_W-1:0] uartTxFrame,
  output logic                    uartTxReady
);
  // ----------------------------------------
  // can node and host sinks
  // ----------------------------------------
  logic [FRAME_W-1:0] canSeen[$];
  logic [FRAME_W-1:0] uartSeen[$];

  // ready wanders per cycle so the heads have to stand while not taken
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      canTxReady  <= 1'b0;
      uartTxReady <= 1'b0;
    end
    else
    begin
      if (canTxValid && canTxReady) canSeen.push_back(canTxFrame);
      if (uartTxValid && uartTxReady) uartSeen.push_back(uartTxFrame);
      canTxReady  <= !stall && ($urandom_range(3) != 0);
      uartTxReady <= !stall && ($urandom_range(3) != 0);
    end
  end
endmodule

// File: dv/tb_msi_mode_status.sv
`timescale 1ns/10ps
module tb_msi_mode_status
  import msi_pkg::*;
;
  localparam int BLK = 16;
  localparam int ACT = 4;
  logic               clk, reset_n, read, write, modeSwitch, stall, waitrequest, irq, nvmWrite;
  logic [ADDR_W-1:0]  address;
  logic [3:0]         byteenable;
  logic [31:0]        writedata, readdata, nvmUartCfg, nvmCanCfg, nvmFilterCfg, runtimeCfgData;
  logic [31:0]        activeUartCfg, activeCanCfg, activeFilterCfg, q, d;
  logic               uartRxValid, canTxValid, canTxReady, canRxValid, uartTxValid, uartTxReady;
  logic               runtimeCanCfgCmd, runtimeFilterCfgCmd, statusQueryCmd, errorClearCmd;
  logic               errorReportValid, canBusOff, canErrorPassive, otherError, configMode;
  logic               runIndicator, faultIndicator;
  logic [FRAME_W-1:0] uartRxFrame, canTxFrame, canRxFrame, uartTxFrame;
  logic [ERR_W-1:0]   errorReport;
  logic [FRAME_W-1:0] sentQ[$];
  int                 errCount, samplesChecked, c;

  msi_mode_status #(.COMPACT(1'b1), .BLINK_CYC(BLK), .ACT_CYC(ACT)) dut (.*);
  msi_far_side far (.*);

  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task reportAndStop();
    if (errCount == 0 && samplesChecked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // request stands until the edge that sees waitrequest low; read data taken at that edge
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] v, output logic [31:0] r);
    int n;
    @(posedge clk);
    address   <= a;
    writedata <= v;
    write     <= wr;
    read      <= !wr;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    r = readdata;
    if (n == 20)
    begin
      check("bus timeout", 1, 0);
      reportAndStop();
    end
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task rst(input logic m);
    @(posedge clk);
    modeSwitch <= m;
    reset_n    <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  task cmd(input int k);
    @(posedge clk);
    statusQueryCmd      <= (k == 0);
    errorClearCmd       <= (k == 1);
    runtimeCanCfgCmd    <= (k == 2);
    runtimeFilterCfgCmd <= (k == 3);
    @(posedge clk);
    {statusQueryCmd, errorClearCmd, runtimeCanCfgCmd, runtimeFilterCfgCmd} <= 4'h0;
    @(negedge clk);
  endtask

  task stream(input bit toCan, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      d = $urandom;
      sentQ.push_back(d);
      uartRxValid <= toCan;
      canRxValid  <= !toCan;
      uartRxFrame <= d;
      canRxFrame  <= d;
    end
    @(posedge clk);
    uartRxValid <= 1'b0;
    canRxValid  <= 1'b0;
  endtask

  task countHigh(input bit flt, input int n, output int k);
    k = 0;
    repeat (n)
    begin
      @(negedge clk);
      k += ((flt ? faultIndicator : runIndicator) === 1'b1);
    end
  endtask

  task waitSeen(input bit toCan, input int n);
    int k;
    for (k = 0; k < 3000 && (toCan ? far.canSeen.size() : far.uartSeen.size()) < n; k++)
      @(posedge clk);
    if (k == 3000)
    begin
      check("drain timeout", 1, 0);
      reportAndStop();
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {read, write, statusQueryCmd, errorClearCmd, runtimeCanCfgCmd, runtimeFilterCfgCmd} = '0;
    {uartRxValid, canRxValid, canBusOff, canErrorPassive, otherError, stall} = '0;
    {address, writedata, uartRxFrame, canRxFrame, errCount, samplesChecked} = '0;
    byteenable = 4'hf;
    modeSwitch = 1'b1;
    reset_n    = 1'b0;
    void'($urandom(50));
    {nvmUartCfg, nvmCanCfg, nvmFilterCfg, runtimeCfgData} = {$urandom, $urandom, $urandom, $urandom};
    rst(1'b1);
    check("configMode", configMode, 1);
    @(posedge clk);
    modeSwitch <= 1'b0;
    countHigh(0, 2 * BLK, c);
    check("config blink", c, BLK);
    check("mode held", configMode, 1);
    stream(1, 1);
    @(negedge clk);
    check("config frame ignored", canTxValid, 0);
    bus(1, REG_CFG_CAN, 32'h1234abcd, q);
    bus(0, REG_CFG_CAN, 32'h0, q);
    check("cfg readback", q, 32'h1234abcd);
    bus(1, REG_CTRL, 32'h1, q);
    countHigh(0, 0, c);
    repeat (4)
    begin
      @(negedge clk);
      c += (nvmWrite === 1'b1);
    end
    check("store pulses", c, 1);
    check("stored can cfg", activeCanCfg, 32'h1234abcd);
    // operation mode, far side stalled so the tx buffer fills and overflows
    rst(1'b0);
    check("operation mode", configMode, 0);
    check("loaded can cfg", activeCanCfg, nvmCanCfg);
    check("loaded uart cfg", activeUartCfg, nvmUartCfg);
    cmd(2);
    check("runtime can cfg", activeCanCfg, runtimeCfgData);
    check("no store", nvmWrite, 0);
    cmd(3);
    check("runtime filter cfg", activeFilterCfg, runtimeCfgData);
    bus(1, REG_CFG_CAN, 32'h0, q);
    check("cfg locked", activeCanCfg, runtimeCfgData);
    bus(1, REG_IRQ_EN, 32'h1, q);
    stall <= 1'b1;
    sentQ.delete();
    stream(1, FIFO_DEPTH_COMPACT + 4);
    repeat (2) @(negedge clk);
    bus(0, REG_ERR, 32'h0, q);
    check("tx overflow", q, 32'h1);
    check("fault steady", faultIndicator, 1);
    check("irq raised", irq, 1);
    cmd(0);
    check("report valid", errorReportValid, 1);
    check("report", errorReport, 1);
    bus(1, REG_IRQ_CLR, 32'h1, q);
    bus(0, REG_IRQ_CLR, 32'h0, q);
    check("clear reads zero", q, 0);
    check("irq cleared", irq, 0);
    bus(0, 8'h40, 32'h0, q);
    check("unmapped", q, 0);
    stall <= 1'b0;
    waitSeen(1, FIFO_DEPTH_COMPACT);
    for (int i = 0; i < FIFO_DEPTH_COMPACT; i++)
      check("can frame", far.canSeen[i], sentQ[i]);
    repeat (3 * ACT) @(negedge clk);
    check("run lit idle", runIndicator, 1);
    bus(0, REG_STATUS, 32'h0, q);
    check("status", q, 32'h1e);
    bus(0, REG_IRQ_STAT, 32'h0, q);
    check("irq status", q, 32'h8);
    check("irq masked", irq, 0);
    cmd(1);
    bus(0, REG_ERR, 32'h0, q);
    check("error cleared", q, 0);
    check("fault dark", faultIndicator, 0);
    stream(1, 1);
    countHigh(0, 4 * ACT, c);
    check("send flash", c, 3 * ACT);
    sentQ.delete();
    stream(0, 3);
    waitSeen(0, 3);
    for (int i = 0; i < 3; i++)
      check("uart frame", far.uartSeen[i], sentQ[i]);
    otherError <= 1'b1;
    repeat (2) @(negedge clk);
    countHigh(1, 2 * BLK, c);
    check("fault flash", c, BLK);
    @(posedge clk);
    otherError      <= 1'b0;
    canErrorPassive <= 1'b1;
    repeat (2) @(negedge clk);
    countHigh(1, 2 * BLK, c);
    check("passive steady", c, 2 * BLK);
    @(posedge clk);
    canBusOff <= 1'b1;
    bus(0, REG_ERR, 32'h0, q);
    check("bus-off error", q, 32'hc);
    check("bus-off steady", faultIndicator, 1);
    bus(0, REG_IRQ_STAT, 32'h0, q);
    check("bus-off event", q, 32'hc);
    reportAndStop();
  end
endmodule
